// file: include/brm_defines.vh
// constants for the board register map and its initialization sequencer
`ifndef BRM_DEFINES_VH
`define BRM_DEFINES_VH

// ----------------------------------------
// clock and timing
// ----------------------------------------
`define BRM_CLK_MHZ 100
`define BRM_CFG_LOAD_US 3000
`define BRM_INIT_US 3000

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define BRM_OFS_BCR 16'h0000
`define BRM_OFS_DIO 16'h0004
`define BRM_OFS_CH0 16'h8000
`define BRM_OFS_CH1 16'h000C
`define BRM_OFS_CH2 16'h0010
`define BRM_OFS_CH3 16'h0014
`define BRM_OFS_INBUF 16'h0018
`define BRM_OFS_RATE_A 16'h001C
`define BRM_OFS_RATE_B 16'h0020
`define BRM_OFS_INCFG 16'h0024
`define BRM_OFS_INFILL 16'h0028
`define BRM_OFS_INTHR 16'h002C
`define BRM_OFS_STATUS 16'h0030
`define BRM_OFS_ASSY 16'h0034
`define BRM_OFS_CAL 16'h0038
`define BRM_OFS_OUTCTL 16'h003C
`define BRM_OFS_OUTTHR 16'h0040
`define BRM_OFS_OUTFILL 16'h0044
`define BRM_OFS_OUTBUF 16'h0048
`define BRM_OFS_RATE_C 16'h004C
`define BRM_OFS_SCR0 16'h0050
`define BRM_OFS_END 16'h0060

// ----------------------------------------
// reset values and config window mask
// ----------------------------------------
`define BRM_DEF_BCR 32'h220200A0
`define BRM_DEF_CH 32'h00008000
`define BRM_DEF_RATE_AC 32'h0000007E
`define BRM_DEF_RATE_B 32'h00002760
`define BRM_DEF_INCFG 32'hFF000400
`define BRM_DEF_THR 32'h0003FFFE
`define BRM_DEF_OUTCTL 32'h0000104F
`define BRM_BAR_MASK 32'hFFFFFF80

// ----------------------------------------
// write masks and board control fields
// ----------------------------------------
`define BRM_MASK_DIV 32'h00FFFFFF
`define BRM_MASK_DIO 32'h01000100
`define BRM_BCR_CMD_MASK 32'h00102900
`define BRM_BCR_RO_MASK 32'h80004400
`define BRM_BIT_AUTOCAL 3
`define BRM_BIT_IN_SWCLK 8
`define BRM_BIT_BURST_BUSY 10
`define BRM_BIT_IN_SWTRIG 11
`define BRM_BIT_IN_CLEAR 13
`define BRM_BIT_IN_THR 14
`define BRM_BIT_IN_OVF 15
`define BRM_BIT_BUF_OUT 19
`define BRM_BIT_OUT_SWCLK 20
`define BRM_BIT_IN_UNF 23
`define BRM_BIT_RESTART 31
`define BRM_BIT_DIO_LO_OE 8
`define BRM_BIT_DIO_HI_OE 24

`endif

// file: src/brm_register_bank.v
// control and status register bank with configuration load and restart sequencer
// ----------------------------------------
// ----------------------------------------
`timescale 1ns/1ps
`include "brm_defines.vh"

module brm_register_bank #(
  parameter LOAD_CYCLES = `BRM_CFG_LOAD_US * `BRM_CLK_MHZ,
  parameter INIT_CYCLES = `BRM_INIT_US * `BRM_CLK_MHZ,
  parameter FILL_W = 18,
  parameter [31:0] ASSY_ID = 32'h00012345 // arbitrary build code, carries no meaning
)(
  input wire i_clk_sys,                  // local bus clock
  input wire i_rst_n,                    // bus reset, active low
  input wire i_lb_req,                   // access request strobe
  input wire i_lb_wr,                    // 1 write, 0 read
  input wire [15:0] i_lb_addr,           // byte address
  input wire [3:0] i_lb_be,              // byte enables
  input wire [31:0] i_lb_wdata,          // write data
  output wire [31:0] o_lb_rdata,         // read data
  output wire o_lb_ack,                  // access completed
  output wire o_lb_retry,                // access refused, try again
  output wire o_lb_err,                  // partial-width access refused
  output wire o_cfg_loading,             // configuration load in progress
  output wire [31:0] o_bar_size_mask,    // window size mask for config space
  output wire o_init_busy,               // restart in progress
  output wire [31:0] o_board_control_word, // control word to the board
  output wire [15:0] o_out_value0,       // output channel 0 code
  output wire [15:0] o_out_value1,       // output channel 1 code
  output wire [15:0] o_out_value2,       // output channel 2 code
  output wire [15:0] o_out_value3,       // output channel 3 code
  output wire [23:0] o_rate_a_div,       // sample rate divider
  output wire [23:0] o_rate_b_div,       // burst rate divider
  output wire [23:0] o_rate_c_div,       // output rate divider
  output wire [31:0] o_in_cfg,           // channel mask and burst size
  output wire [31:0] o_in_level_mark,    // input threshold
  output wire [31:0] o_out_buf_ctl,      // buffered output control
  output wire [31:0] o_out_level_mark,   // output threshold
  output wire o_in_sw_clock,             // single input sample pulse
  output wire o_in_sw_trigger,           // single burst pulse
  output wire o_out_sw_clock,            // single output clock pulse
  output wire o_autocal_start,           // autocalibration running
  output wire o_in_buf_clear,            // empty input buffer pulse
  output wire o_out_buf_clear,           // empty output buffer pulse
  output wire o_in_pop,                  // input buffer read pulse
  output wire o_out_push,                // output buffer write pulse
  output wire [31:0] o_out_wdata,        // output buffer data
  output wire [15:0] o_dio_out,          // digital port drive value, always zero
  output wire [1:0] o_dio_oe,            // digital port byte enables
  input wire [23:0] i_in_data,           // input buffer head word
  input wire [FILL_W-1:0] i_in_fill,     // input buffer count
  input wire [FILL_W-1:0] i_out_fill,    // output buffer count
  input wire i_burst_busy,               // burst in progress
  input wire i_in_overflow,              // input overflow event pulse
  input wire i_in_underflow,             // input underflow event pulse
  input wire i_autocal_done,             // autocalibration finished pulse
  input wire [15:0] i_dio_pin            // digital port pin levels
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  localparam NSLOT = 24;
  localparam SLOT_BCR = 0;
  localparam SLOT_DIO = 1;
  localparam SLOT_CH0 = 2;
  localparam SLOT_CH3 = 5;
  localparam SLOT_INBUF = 6;
  localparam SLOT_RATE_A = 7;
  localparam SLOT_RATE_B = 8;
  localparam SLOT_INCFG = 9;
  localparam SLOT_INFILL = 10;
  localparam SLOT_INTHR = 11;
  localparam SLOT_ASSY = 13;
  localparam SLOT_OUTCTL = 15;
  localparam SLOT_OUTTHR = 16;
  localparam SLOT_OUTFILL = 17;
  localparam SLOT_OUTBUF = 18;
  localparam SLOT_RATE_C = 19;

  // stored image restored by both bus reset and restart
  function [31:0] def_val;
    input integer s;
    begin
      case (s)
        SLOT_BCR: def_val = `BRM_DEF_BCR;
        2, 3, 4, 5: def_val = `BRM_DEF_CH;
        SLOT_RATE_A: def_val = `BRM_DEF_RATE_AC;
        SLOT_RATE_C: def_val = `BRM_DEF_RATE_AC;
        SLOT_RATE_B: def_val = `BRM_DEF_RATE_B;
        SLOT_INCFG: def_val = `BRM_DEF_INCFG;
        SLOT_INTHR: def_val = `BRM_DEF_THR;
        SLOT_OUTTHR: def_val = `BRM_DEF_THR;
        SLOT_OUTCTL: def_val = `BRM_DEF_OUTCTL;
        default: def_val = 32'h00000000;
      endcase
    end
  endfunction

  function [31:0] wr_mask;
    input integer s;
    begin
      case (s)
        SLOT_BCR: wr_mask = ~`BRM_BCR_RO_MASK;
        SLOT_DIO: wr_mask = `BRM_MASK_DIO;
        SLOT_RATE_A, SLOT_RATE_B, SLOT_RATE_C: wr_mask = `BRM_MASK_DIV;
        SLOT_INBUF, SLOT_INFILL, SLOT_ASSY, SLOT_OUTFILL, SLOT_OUTBUF:
          wr_mask = 32'h00000000;
        default: wr_mask = 32'hFFFFFFFF;
      endcase
    end
  endfunction

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  reg [4:0] slot;
  reg slot_ok;

  always @*
  begin
    slot = i_lb_addr[6:2];
    slot_ok = 1'b0;
    if (i_lb_addr == `BRM_OFS_CH0)
    begin
      slot = SLOT_CH0[4:0];
      slot_ok = 1'b1;
    end
    else if (i_lb_addr < `BRM_OFS_END && i_lb_addr[1:0] == 2'b00 &&
             i_lb_addr[6:2] != SLOT_CH0[4:0])
    begin
      slot_ok = 1'b1;
    end
  end

  reg loading_ff;
  reg [31:0] regs_ff [0:NSLOT-1];
  reg init_busy_ff;

  wire full_word = (i_lb_be == 4'hF);
  wire acc_go = i_lb_req & ~loading_ff & full_word;
  wire wr_go = acc_go & i_lb_wr & slot_ok;
  wire rd_go = acc_go & ~i_lb_wr;
  // channel registers are locked out while the output buffer owns the outputs
  wire ch_lock = regs_ff[SLOT_BCR][`BRM_BIT_BUF_OUT] & (slot >= SLOT_CH0[4:0]) &
                 (slot <= SLOT_CH3[4:0]);
  wire init_go = wr_go & (slot == SLOT_BCR[4:0]) & i_lb_wdata[`BRM_BIT_RESTART] &
                 ~init_busy_ff;

  // ----------------------------------------
  // configuration load and restart timing
  // ----------------------------------------
  reg [31:0] load_cnt_ff;
  reg [31:0] init_cnt_ff;

  always @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      loading_ff <= 1'b1;
      load_cnt_ff <= 32'h00000000;
      init_busy_ff <= 1'b0;
      init_cnt_ff <= 32'h00000000;
    end
    else
    begin
      if (loading_ff)
      begin
        load_cnt_ff <= load_cnt_ff + 32'h00000001;
        if (load_cnt_ff >= LOAD_CYCLES - 1)
          loading_ff <= 1'b0;
      end
      if (init_go)
      begin
        init_busy_ff <= 1'b1;
        init_cnt_ff <= 32'h00000000;
      end
      else if (init_busy_ff)
      begin
        init_cnt_ff <= init_cnt_ff + 32'h00000001;
        if (init_cnt_ff >= INIT_CYCLES - 1)
          init_busy_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // board control word next value
  // ----------------------------------------
  reg [31:0] nxt_bcr;

  always @*
  begin
    // command pulses last exactly one cycle
    nxt_bcr = regs_ff[SLOT_BCR] & ~`BRM_BCR_CMD_MASK;
    if (i_autocal_done)
      nxt_bcr[`BRM_BIT_AUTOCAL] = 1'b0;
    if (wr_go && slot == SLOT_BCR[4:0])
      nxt_bcr = (nxt_bcr & `BRM_BCR_RO_MASK) | (i_lb_wdata & ~`BRM_BCR_RO_MASK);
    // events win over a clearing write in the same cycle
    nxt_bcr[`BRM_BIT_IN_OVF] = nxt_bcr[`BRM_BIT_IN_OVF] | i_in_overflow;
    nxt_bcr[`BRM_BIT_IN_UNF] = nxt_bcr[`BRM_BIT_IN_UNF] | i_in_underflow;
    nxt_bcr[`BRM_BIT_BURST_BUSY] = i_burst_busy;
    nxt_bcr[`BRM_BIT_IN_THR] = (i_in_fill > regs_ff[SLOT_INTHR][FILL_W-1:0]);
    nxt_bcr[`BRM_BIT_RESTART] = 1'b0;
  end

  // ----------------------------------------
  // register file
  // ----------------------------------------
  integer k;

  always @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      for (k = 0; k < NSLOT; k = k + 1)
        regs_ff[k] <= def_val(k);
    end
    else if (init_go)
    begin
      for (k = 0; k < NSLOT; k = k + 1)
        regs_ff[k] <= def_val(k);
    end
    else
    begin
      if (wr_go && !ch_lock)
        regs_ff[slot] <= (regs_ff[slot] & ~wr_mask(slot)) |
                         (i_lb_wdata & wr_mask(slot));
      regs_ff[SLOT_BCR] <= nxt_bcr;
    end
  end

  // ----------------------------------------
  // digital port pin synchroniser
  // ----------------------------------------
  reg [15:0] dio_s1_ff;
  reg [15:0] dio_s2_ff;
  reg [15:0] dio_s3_ff;
  reg [15:0] dio_val_ff;
  wire [15:0] dio_agree = ~(dio_s2_ff ^ dio_s3_ff);

  always @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      dio_s1_ff <= 16'h0000;
      dio_s2_ff <= 16'h0000;
      dio_s3_ff <= 16'h0000;
      dio_val_ff <= 16'h0000;
    end
    else
    begin
      dio_s1_ff <= i_dio_pin;
      dio_s2_ff <= dio_s1_ff;
      dio_s3_ff <= dio_s2_ff;
      dio_val_ff <= (dio_agree & dio_s3_ff) | (~dio_agree & dio_val_ff);
    end
  end

  // ----------------------------------------
  // read path and answers
  // ----------------------------------------
  reg [31:0] rd_mux;
  reg [31:0] rdata_ff;
  reg ack_ff;
  reg retry_ff;
  reg err_ff;
  reg pop_ff;
  reg push_ff;
  reg [31:0] owdata_ff;
  reg in_clr_ff;
  reg out_clr_ff;
  reg [31:0] bar_ff;

  always @*
  begin
    rd_mux = 32'h00000000;
    if (!slot_ok)
      rd_mux = 32'h00000000;
    else
    begin
      case (slot)
        SLOT_BCR[4:0]:
        begin
          rd_mux = regs_ff[SLOT_BCR];
          rd_mux[`BRM_BIT_RESTART] = init_busy_ff;
        end
        SLOT_DIO[4:0]:
          rd_mux = {7'h00, regs_ff[SLOT_DIO][`BRM_BIT_DIO_HI_OE], dio_val_ff[15:8],
                    7'h00, regs_ff[SLOT_DIO][`BRM_BIT_DIO_LO_OE], dio_val_ff[7:0]};
        SLOT_INBUF[4:0]: rd_mux = {8'h00, i_in_data};
        SLOT_INFILL[4:0]: rd_mux = {{(32-FILL_W){1'b0}}, i_in_fill};
        SLOT_ASSY[4:0]: rd_mux = ASSY_ID;
        SLOT_OUTFILL[4:0]: rd_mux = {{(32-FILL_W){1'b0}}, i_out_fill};
        SLOT_OUTBUF[4:0]: rd_mux = 32'h00000000;
        default: rd_mux = regs_ff[slot];
      endcase
    end
  end

  always @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rdata_ff <= 32'h00000000;
      ack_ff <= 1'b0;
      retry_ff <= 1'b0;
      err_ff <= 1'b0;
      pop_ff <= 1'b0;
      push_ff <= 1'b0;
      owdata_ff <= 32'h00000000;
      in_clr_ff <= 1'b0;
      out_clr_ff <= 1'b0;
      bar_ff <= 32'h00000000;
    end
    else
    begin
      ack_ff <= acc_go;
      retry_ff <= i_lb_req & loading_ff;
      err_ff <= i_lb_req & ~loading_ff & ~full_word;
      rdata_ff <= rd_go ? rd_mux : 32'h00000000;
      pop_ff <= rd_go & slot_ok & (slot == SLOT_INBUF[4:0]);
      push_ff <= wr_go & (slot == SLOT_OUTBUF[4:0]);
      if (wr_go && slot == SLOT_OUTBUF[4:0])
        owdata_ff <= i_lb_wdata;
      in_clr_ff <= init_go | (~init_go & nxt_bcr[`BRM_BIT_IN_CLEAR]);
      out_clr_ff <= init_go;
      bar_ff <= `BRM_BAR_MASK;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign o_lb_rdata = rdata_ff;
  assign o_lb_ack = ack_ff;
  assign o_lb_retry = retry_ff;
  assign o_lb_err = err_ff;
  assign o_cfg_loading = loading_ff;
  assign o_bar_size_mask = bar_ff;
  assign o_init_busy = init_busy_ff;
  assign o_board_control_word = regs_ff[SLOT_BCR];
  assign o_out_value0 = regs_ff[2][15:0];
  assign o_out_value1 = regs_ff[3][15:0];
  assign o_out_value2 = regs_ff[4][15:0];
  assign o_out_value3 = regs_ff[5][15:0];
  assign o_rate_a_div = regs_ff[SLOT_RATE_A][23:0];
  assign o_rate_b_div = regs_ff[SLOT_RATE_B][23:0];
  assign o_rate_c_div = regs_ff[SLOT_RATE_C][23:0];
  assign o_in_cfg = regs_ff[SLOT_INCFG];
  assign o_in_level_mark = regs_ff[SLOT_INTHR];
  assign o_out_buf_ctl = regs_ff[SLOT_OUTCTL];
  assign o_out_level_mark = regs_ff[SLOT_OUTTHR];
  assign o_in_sw_clock = regs_ff[SLOT_BCR][`BRM_BIT_IN_SWCLK];
  assign o_in_sw_trigger = regs_ff[SLOT_BCR][`BRM_BIT_IN_SWTRIG];
  assign o_out_sw_clock = regs_ff[SLOT_BCR][`BRM_BIT_OUT_SWCLK];
  assign o_autocal_start = regs_ff[SLOT_BCR][`BRM_BIT_AUTOCAL];
  assign o_in_buf_clear = in_clr_ff;
  assign o_out_buf_clear = out_clr_ff;
  assign o_in_pop = pop_ff;
  assign o_out_push = push_ff;
  assign o_out_wdata = owdata_ff;
  assign o_dio_out = regs_ff[SLOT_DIO][15:0] & 16'h0000;
  assign o_dio_oe = {regs_ff[SLOT_DIO][`BRM_BIT_DIO_HI_OE],
                     regs_ff[SLOT_DIO][`BRM_BIT_DIO_LO_OE]};

endmodule // brm_register_bank

// file: tb/brm_host_model.sv
// host-side bus master model issuing one-word register accesses, except writes to BRM_OFS_CAL, which it drives with the request low
`timescale 1ns/1ps
`include "brm_defines.vh"

module brm_host_model (
  input wire i_clk_sys,          // clock
  output logic o_req,            // request strobe
  output logic o_wr,             // write select
  output logic [15:0] o_addr,    // byte address
  output logic [3:0] o_be,       // byte enables
  output logic [31:0] o_wdata    // write data
);
  initial
  begin
    o_req = 1'b0;
    o_wr = 1'b0;
    o_addr = 16'h0000;
    o_be = 4'h0;
    o_wdata = 32'h00000000;
  end

  // released qualifiers show the inverse of their last value, so late sampling is caught
  task automatic access(input logic wr, input logic [15:0] addr, input logic [3:0] be,
    input logic [31:0] data);
    @(negedge i_clk_sys);
    o_req <= !(wr && addr == `BRM_OFS_CAL);
    o_wr <= wr;
    o_addr <= addr;
    o_be <= be;
    o_wdata <= data;
    @(negedge i_clk_sys);
    o_req <= 1'b0;
    o_wr <= ~wr;
    o_addr <= ~addr;
    o_be <= ~be;
    o_wdata <= ~data;
  endtask
endmodule // brm_host_model

// file: tb/brm_register_bank_sva.sv
// assertion checker for the board register bank ports
`timescale 1ns/1ps
`include "brm_defines.vh"

module brm_register_bank_sva #(
  parameter LOAD_CYCLES = 20,
  parameter INIT_CYCLES = 10
)(
  input wire i_clk_sys,                  // clock
  input wire i_rst_n,                    // bus reset, active low
  input wire i_lb_req,                   // request strobe
  input wire i_lb_wr,                    // write select
  input wire [15:0] i_lb_addr,           // byte address
  input wire [3:0] i_lb_be,              // byte enables
  input wire [31:0] i_lb_wdata,          // write data
  input wire [31:0] o_lb_rdata,          // read data
  input wire o_lb_ack,                   // done
  input wire o_lb_retry,                 // retry
  input wire o_lb_err,                   // width error
  input wire o_cfg_loading,              // config load running
  input wire [31:0] o_bar_size_mask,     // window mask
  input wire o_init_busy,                // restart running
  input wire [31:0] o_board_control_word, // control word
  input wire [23:0] o_rate_a_div,        // sample divider
  input wire o_in_buf_clear,             // input clear pulse
  input wire o_out_buf_clear,            // output clear pulse
  input wire o_in_pop                    // input read pulse
);
  reg [31:0] load_cnt_ff;
  reg [31:0] init_cnt_ff;
  wire [31:0] nxt_load_cnt = o_cfg_loading ? load_cnt_ff + 32'h1 : 32'h0;
  wire [31:0] nxt_init_cnt = o_init_busy ? init_cnt_ff + 32'h1 : 32'h0;

  // run lengths are counted here because they exceed any unrolled repetition
  always @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      load_cnt_ff <= 32'h0;
      init_cnt_ff <= 32'h0;
    end
    else
    begin
      load_cnt_ff <= nxt_load_cnt;
      init_cnt_ff <= nxt_init_cnt;
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  // ----------------------------------------
  // access sequences
  // ----------------------------------------
  sequence s_take_ok;
    i_lb_req && (i_lb_be == 4'hF) && !o_cfg_loading;
  endsequence
  sequence s_restart;
    s_take_ok ##0 (i_lb_wr && i_lb_addr == `BRM_OFS_BCR && i_lb_wdata[31] && !o_init_busy);
  endsequence
  sequence s_rate_read;
    s_take_ok ##0 (!i_lb_wr && i_lb_addr == `BRM_OFS_RATE_A);
  endsequence

  AST_ONE_ANSWER: assert property (i_lb_req |=> $onehot({o_lb_ack, o_lb_retry, o_lb_err}))
    else $error("request not answered by exactly one response");
  AST_NO_SPURIOUS: assert property ((o_lb_ack || o_lb_retry || o_lb_err) |-> $past(i_lb_req))
    else $error("response without request");
  AST_NARROW_ERR: assert property ((i_lb_req && i_lb_be != 4'hF && !o_cfg_loading)
    |=> o_lb_err && o_lb_rdata == 32'h0)
    else $error("narrow access not refused");
  AST_LOAD_RETRY: assert property ((i_lb_req && o_cfg_loading) |=> o_lb_retry)
    else $error("access during load not retried");
  AST_BAR_WINDOW: assert property ($past(i_rst_n) |-> o_bar_size_mask == `BRM_BAR_MASK)
    else $error("window mask wrong");
  AST_LOAD_ONCE: assert property (!$rose(o_cfg_loading))
    else $error("config load restarted without bus reset");
  AST_LOAD_BOUND: assert property (load_cnt_ff <= LOAD_CYCLES + 1)
    else $error("config load too long");
  AST_INIT_BOUND: assert property (init_cnt_ff <= INIT_CYCLES + 1)
    else $error("restart too long");
  AST_RESTART_DEF: assert property (s_restart |=> o_init_busy && !o_cfg_loading
    && (o_board_control_word & ~`BRM_BCR_RO_MASK) == (`BRM_DEF_BCR & ~`BRM_BCR_RO_MASK)
    && {8'h00, o_rate_a_div} == `BRM_DEF_RATE_AC)
    else $error("restart did not restore defaults");
  AST_RESTART_CLEAR: assert property (s_restart |-> ##[1:2] (o_in_buf_clear && o_out_buf_clear))
    else $error("restart did not empty buffers");
  AST_RATE_WIDTH: assert property (s_rate_read |=> o_lb_ack && o_lb_rdata[31:24] == 8'h00
    && o_lb_rdata[23:0] == o_rate_a_div)
    else $error("divider read not 24 bits");
  AST_POP_READ: assert property (o_in_pop |-> o_lb_ack && !$past(i_lb_wr)
    && $past(i_lb_addr) == `BRM_OFS_INBUF)
    else $error("input pop without buffer read");
endmodule // brm_register_bank_sva

bind brm_register_bank brm_register_bank_sva #(.LOAD_CYCLES(LOAD_CYCLES),
  .INIT_CYCLES(INIT_CYCLES)) u_brm_register_bank_sva (.i_clk_sys(i_clk_sys),
  .i_rst_n(i_rst_n), .i_lb_req(i_lb_req), .i_lb_wr(i_lb_wr), .i_lb_addr(i_lb_addr),
  .i_lb_be(i_lb_be), .i_lb_wdata(i_lb_wdata), .o_lb_rdata(o_lb_rdata), .o_lb_ack(o_lb_ack),
  .o_lb_retry(o_lb_retry), .o_lb_err(o_lb_err), .o_cfg_loading(o_cfg_loading),
  .o_bar_size_mask(o_bar_size_mask), .o_init_busy(o_init_busy),
  .o_board_control_word(o_board_control_word), .o_rate_a_div(o_rate_a_div),
  .o_in_buf_clear(o_in_buf_clear), .o_out_buf_clear(o_out_buf_clear), .o_in_pop(o_in_pop));

// file: tb/brm_register_bank_tb_top.sv
// self-checking testbench for the board register bank
`timescale 1ns/1ps
`include "brm_defines.vh"

module brm_register_bank_tb_top;
  localparam int LOAD_N = 20;
  localparam int INIT_N = 10;
  typedef struct {logic [2:0] kind; logic chk; logic [31:0] data;} brm_note_t;
  logic i_clk_sys = 1'b0;
  logic i_rst_n = 1'b0;
  wire req, wr, ack, retry, err, loading, ibusy;
  wire [15:0] addr;
  wire [15:0] v1;
  wire [3:0] be;
  wire [31:0] wdata, rdata, bar;
  wire [1:0] dio_oe;
  logic [23:0] in_data = 24'h000000;
  logic [17:0] in_fill = 18'h00000;
  logic [17:0] out_fill = 18'h00000;
  logic burst = 1'b0, ovf = 1'b0, unf = 1'b0, acal_done = 1'b0;
  logic [15:0] dio_pin = 16'h0000;
  int n_mismatch = 0;
  int checks_done = 0;
  int s, i, k;
  logic [31:0] d;
  brm_note_t notes[$];
  brm_note_t seen;
  logic [15:0] def_addr [21] = '{`BRM_OFS_BCR, `BRM_OFS_CH0, `BRM_OFS_CH1, `BRM_OFS_CH2,
    `BRM_OFS_CH3, `BRM_OFS_RATE_A, `BRM_OFS_RATE_B, `BRM_OFS_INCFG, `BRM_OFS_INFILL,
    `BRM_OFS_INTHR, `BRM_OFS_OUTCTL, `BRM_OFS_OUTTHR, `BRM_OFS_OUTFILL, `BRM_OFS_RATE_C,
    `BRM_OFS_SCR0, 16'h0054, 16'h0058, 16'h005C, 16'h0008, 16'h0060, `BRM_OFS_OUTBUF};
  logic [31:0] def_val [21] = '{`BRM_DEF_BCR, `BRM_DEF_CH, `BRM_DEF_CH, `BRM_DEF_CH,
    `BRM_DEF_CH, `BRM_DEF_RATE_AC, `BRM_DEF_RATE_B, `BRM_DEF_INCFG, 32'h0, `BRM_DEF_THR,
    `BRM_DEF_OUTCTL, `BRM_DEF_THR, 32'h0, `BRM_DEF_RATE_AC, 32'h0, 32'h0, 32'h0, 32'h0,
    32'h0, 32'h0, 32'h0};

  always #5 i_clk_sys = ~i_clk_sys;

  brm_host_model u_brm_host_model (.i_clk_sys(i_clk_sys), .o_req(req), .o_wr(wr),
    .o_addr(addr), .o_be(be), .o_wdata(wdata));

  brm_register_bank #(.LOAD_CYCLES(LOAD_N), .INIT_CYCLES(INIT_N)) u_brm_register_bank (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_lb_req(req), .i_lb_wr(wr),
    .i_lb_addr(addr), .i_lb_be(be), .i_lb_wdata(wdata), .o_lb_rdata(rdata),
    .o_lb_ack(ack), .o_lb_retry(retry), .o_lb_err(err), .o_cfg_loading(loading),
    .o_bar_size_mask(bar), .o_init_busy(ibusy), .o_board_control_word(),
    .o_out_value0(), .o_out_value1(v1), .o_out_value2(), .o_out_value3(), .o_rate_a_div(),
    .o_rate_b_div(), .o_rate_c_div(), .o_in_cfg(), .o_in_level_mark(), .o_out_buf_ctl(),
    .o_out_level_mark(), .o_in_sw_clock(), .o_in_sw_trigger(), .o_out_sw_clock(),
    .o_autocal_start(), .o_in_buf_clear(), .o_out_buf_clear(), .o_in_pop(),
    .o_out_push(), .o_out_wdata(), .o_dio_out(), .o_dio_oe(dio_oe), .i_in_data(in_data),
    .i_in_fill(in_fill), .i_out_fill(out_fill), .i_burst_busy(burst),
    .i_in_overflow(ovf), .i_in_underflow(unf), .i_autocal_done(acal_done),
    .i_dio_pin(dio_pin));

  // ----------------------------------------
  // checking and bus tasks
  // ----------------------------------------
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", name, exp, got);
      n_mismatch++;
    end
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    notes.push_back('{3'b001, 1'b1, exp});
    u_brm_host_model.access(1'b0, a, 4'hF, 32'h0);
  endtask

  task automatic wrt(input logic [15:0] a, input logic [31:0] v);
    notes.push_back('{3'b001, 1'b0, 32'h0});
    u_brm_host_model.access(1'b1, a, 4'hF, v);
  endtask

  task automatic refuse(input logic w, input logic [3:0] b, input logic [2:0] kind);
    notes.push_back('{kind, 1'b0, 32'h0});
    u_brm_host_model.access(w, `BRM_OFS_SCR0, b, 32'hA5A5A5A5);
  endtask

  task automatic wait_idle(input int lim, input string name);
    k = 0;
    while ((loading | ibusy) !== 1'b0 && k < lim)
    begin
      @(negedge i_clk_sys);
      k++;
    end
    check(name, 32'h0, {31'h0, loading | ibusy});
  endtask

  task automatic pulse_in(input int which);
    @(negedge i_clk_sys);
    {acal_done, unf, ovf} = 3'b001 << which;
    @(negedge i_clk_sys);
    {acal_done, unf, ovf} = 3'b000;
  endtask

  task finish_test;
    $display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // responses are settled by the falling edge and stand for that whole cycle
  always @(negedge i_clk_sys)
  begin
    if (ack === 1'b1 || retry === 1'b1 || err === 1'b1)
    begin
      seen = notes.pop_front();
      check("answer", {29'h0, seen.kind}, {29'h0, err, retry, ack});
      if (seen.chk)
        check("rdata", seen.data, rdata);
    end
  end

  initial
  begin
    #100000;
    n_mismatch++;
    $display("[ERR] watchdog expected done seen hang");
    finish_test();
  end

  initial
  begin
    s = $urandom(26);
    repeat (20) @(negedge i_clk_sys);
    i_rst_n = 1'b1;
    for (i = 0; i < 3; i++) refuse(1'b0, 4'hF, 3'b010);
    wait_idle(LOAD_N + 4, "load_done");
    check("bar_mask", `BRM_BAR_MASK, bar);
    for (i = 0; i < 21; i++) rd(def_addr[i], def_val[i]);
    for (i = 0; i < 4; i++)
    begin
      d = $urandom;
      wrt(`BRM_OFS_SCR0 + 16'(4 * i), d);
      rd(`BRM_OFS_SCR0 + 16'(4 * i), d);
    end
    wrt(`BRM_OFS_SCR0, d);
    refuse(1'b1, 4'h3, 3'b100);
    refuse(1'b0, 4'h1, 3'b100);
    rd(`BRM_OFS_SCR0, d);
    wrt(`BRM_OFS_RATE_A, 32'hFFFFFFFF);
    wrt(`BRM_OFS_RATE_B, 32'hFFFFFFFF);
    wrt(`BRM_OFS_RATE_C, 32'hFFFFFFFF);
    rd(`BRM_OFS_RATE_A, `BRM_MASK_DIV);
    rd(`BRM_OFS_RATE_B, `BRM_MASK_DIV);
    rd(`BRM_OFS_RATE_C, `BRM_MASK_DIV);
    in_fill = 18'($urandom) & 18'h0FFFF;
    out_fill = 18'($urandom);
    in_data = 24'($urandom);
    wrt(`BRM_OFS_INFILL, 32'hFFFFFFFF);
    rd(`BRM_OFS_INFILL, {14'h0, in_fill});
    rd(`BRM_OFS_OUTFILL, {14'h0, out_fill});
    rd(`BRM_OFS_INBUF, {8'h00, in_data});
    dio_pin = 16'($urandom);
    wrt(`BRM_OFS_DIO, `BRM_MASK_DIO);
    repeat (6) @(negedge i_clk_sys);
    rd(`BRM_OFS_DIO, {7'h0, 1'b1, dio_pin[15:8], 7'h0, 1'b1, dio_pin[7:0]});
    check("dio_oe", 32'h3, {30'h0, dio_oe});
    in_fill = 18'h3FFFF;
    burst = 1'b1;
    wrt(`BRM_OFS_BCR, `BRM_DEF_BCR | 32'h00002900);
    pulse_in(0);
    pulse_in(1);
    repeat (4) @(negedge i_clk_sys);
    rd(`BRM_OFS_BCR, `BRM_DEF_BCR | 32'h0080C400);
    in_fill = 18'h00000;
    out_fill = 18'h00000;
    burst = 1'b0;
    wrt(`BRM_OFS_BCR, `BRM_DEF_BCR | 32'h00000008);
    rd(`BRM_OFS_BCR, `BRM_DEF_BCR | 32'h00000008);
    pulse_in(2);
    rd(`BRM_OFS_BCR, `BRM_DEF_BCR);
    wrt(`BRM_OFS_CH1, 32'h00001234);
    wrt(`BRM_OFS_BCR, 32'h80000000);
    rd(`BRM_OFS_BCR, `BRM_DEF_BCR | 32'h80000000);
    wait_idle(INIT_N + 4, "init_done");
    check("bar_kept", `BRM_BAR_MASK, bar);
    check("dio_oe", 32'h0, {30'h0, dio_oe});
    check("out_value1", `BRM_DEF_CH, {16'h0, v1});
    for (i = 0; i < 21; i++) rd(def_addr[i], def_val[i]);
    repeat (4) @(negedge i_clk_sys);
    check("pending", 32'h0, 32'(notes.size()));
    finish_test();
  end
endmodule // brm_register_bank_tb_top
